// ### design/lie_defines.svh
// Purpose: constants of the link exchange block
// Assumes: sys_clk at 250 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef LIE_DEFINES_SVH
`define LIE_DEFINES_SVH

`define LIE_CLK_MHZ 250
`define LIE_T_RESET_NS 6400
`define LIE_T_WAIT_NS 12800
`define LIE_T_DISC_NS 850
// least times round up
`define LIE_CYC_RESET ((`LIE_T_RESET_NS * `LIE_CLK_MHZ + 999) / 1000)
`define LIE_CYC_WAIT ((`LIE_T_WAIT_NS * `LIE_CLK_MHZ + 999) / 1000)
`define LIE_CYC_DISC ((`LIE_T_DISC_NS * `LIE_CLK_MHZ + 999) / 1000)
`define LIE_TX_DIV 5'h19
`define LIE_FCT_CREDIT 6'h08
`define LIE_CREDIT_MAX 6'h38
`define LIE_NULL_PATTERN 9'h0e8

`define LIE_ADDR_CTRL 8'h00
`define LIE_ADDR_STATUS 8'h04
`define LIE_ADDR_ERRS 8'h08
`define LIE_CTRL_DIS 0
`define LIE_CTRL_START 1
`define LIE_CTRL_AUTO 2
`define LIE_CTRL_RESET 3'h0
`define LIE_ERR_DISC 0
`define LIE_ERR_PAR 1
`define LIE_ERR_ESC 2
`define LIE_ERR_CRED 3
`define LIE_ERR_SEQ 4

`define LIE_CODE_FCT 2'h0
`define LIE_CODE_EOP 2'h1
`define LIE_CODE_EEP 2'h2
`define LIE_CODE_ESC 2'h3

`endif

// ### design/lie_link_exchange.sv
// Purpose: exchange-level state machine of one data-strobe link end
// Assumes: APB slave at sys_clk; host room pulses are single cycles
// Notes: tx bit rate is sys_clk / 25; no time-code transmit
`include "lie_defines.svh"
module lie_link_exchange (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_room,
    input wire logic tx_valid,
    input wire logic [8:0] tx_data,
    output logic tx_ack,
    output logic tx_ready,
    output logic rx_valid,
    output logic [8:0] rx_data,
    output logic link_running,
    input wire logic data_in,
    input wire logic strobe_in,
    output logic data_out,
    output logic strobe_out
);
    localparam logic [11:0] CYC_RESET = 12'(`LIE_CYC_RESET);
    localparam logic [11:0] CYC_WAIT = 12'(`LIE_CYC_WAIT);

    lie_pkg::lie_state_t state, next_state;
    logic [11:0] timer;
    logic [2:0] ctrl;
    logic [4:0] errs;
    logic got_null;
    logic rx_on, tx_on, link_enabled;
    logic bit_v, bit_d, disc_p;
    logic synced, resc, rpar, rflag, rprev, last_eop;
    logic [8:0] hunt;
    logic [3:0] rcnt;
    logic [7:0] rsh;
    logic [8:0] rchar;
    logic null_p, fct_p, nchar_p, time_p, par_p, esc_p;
    logic seq_p, cred_p, rx_err;
    logic [5:0] tx_cred, rx_cred;
    logic [2:0] owed;
    logic [4:0] div;
    logic tick;
    logic [9:0] tsh, nvec;
    logic [3:0] tlen, nlen;
    logic tprev, pend, nprev, npend, nhost, nfct;
    logic fct_sent, host_sent;
    logic apb_done;

    function automatic logic [9:0] ctl_char(input logic [1:0] code, input logic prev);
        // odd parity over previous data bits, parity and flag
        ctl_char = {6'h00, code[0], code[1], 1'b1, prev};
    endfunction

    function automatic logic is_state(input lie_pkg::lie_state_t s, input logic [5:0] m);
        is_state = |(s & m);
    endfunction

    assign rx_on = state != lie_pkg::st_err_reset;
    assign tx_on = is_state(state, 6'h38);
    assign link_enabled = ~ctrl[`LIE_CTRL_DIS]
        & (ctrl[`LIE_CTRL_START] | (ctrl[`LIE_CTRL_AUTO] & got_null));
    assign seq_p = (fct_p & is_state(state, 6'h0e))
        | ((nchar_p | time_p) & state != lie_pkg::st_run);
    assign rx_err = disc_p | par_p | esc_p | seq_p | cred_p;
    assign apb_done = psel & penable & pready;

    lie_rx_front u_front (
        .sys_clk(sys_clk),
        .reset(reset),
        .data_in(data_in),
        .strobe_in(strobe_in),
        .rx_enable(rx_on),
        .bit_valid(bit_v),
        .bit_data(bit_d),
        .disc_err(disc_p)
    );

    always_comb begin
        next_state = state;
        case (state)
            lie_pkg::st_err_reset: begin
                if (timer >= CYC_RESET - 12'h001) next_state = lie_pkg::st_err_wait;
            end
            // wait dwell, no move on NULL
            lie_pkg::st_err_wait: begin
                if (rx_err) next_state = lie_pkg::st_err_reset;
                else if (timer >= CYC_WAIT - 12'h001) next_state = lie_pkg::st_ready;
            end
            lie_pkg::st_ready: begin
                if (rx_err) next_state = lie_pkg::st_err_reset;
                else if (link_enabled) next_state = lie_pkg::st_started;
            end
            lie_pkg::st_started: begin
                if (rx_err || timer >= CYC_WAIT - 12'h001) next_state = lie_pkg::st_err_reset;
                else if (got_null) next_state = lie_pkg::st_connecting;
            end
            lie_pkg::st_connecting: begin
                if (rx_err || timer >= CYC_WAIT - 12'h001) next_state = lie_pkg::st_err_reset;
                else if (fct_p) next_state = lie_pkg::st_run;
            end
            // leave run on disable or error
            lie_pkg::st_run: begin
                if (rx_err || ctrl[`LIE_CTRL_DIS]) next_state = lie_pkg::st_err_reset;
            end
            default: next_state = lie_pkg::st_err_reset;
        endcase
    end

    // reset and error recovery enter ErrorReset
    always_ff @(posedge sys_clk) begin
        if (reset) state <= lie_pkg::st_err_reset;
        else state <= next_state;
    end

    always_ff @(posedge sys_clk) begin
        if (reset || next_state != state) timer <= 12'h000;
        else if (timer != 12'hfff) timer <= timer + 12'h001;
    end

    // got-NULL latched, cleared only in ErrorReset
    always_ff @(posedge sys_clk) begin
        if (reset || !rx_on) got_null <= 1'b0;
        else if (null_p) got_null <= 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !rx_on) begin
            synced <= 1'b0;
            hunt <= 9'h000;
            rcnt <= 4'h0;
            resc <= 1'b0;
            rpar <= 1'b0;
            rflag <= 1'b0;
            rprev <= 1'b0;
            rsh <= 8'h00;
            rchar <= 9'h000;
            {null_p, fct_p, nchar_p, time_p, par_p, esc_p} <= 6'h00;
        end else begin
            {null_p, fct_p, nchar_p, time_p, par_p, esc_p} <= 6'h00;
            if (bit_v && !synced) begin
                hunt <= {hunt[7:0], bit_d};
                if ({hunt[7:0], bit_d} == `LIE_NULL_PATTERN) begin
                    // last bit of the pattern is the next parity bit
                    synced <= 1'b1;
                    null_p <= 1'b1;
                    rcnt <= 4'h1;
                    rpar <= bit_d;
                    rprev <= 1'b0;
                end
            end else if (bit_v) begin
                if (rcnt == 4'h0) begin
                    rpar <= bit_d;
                    rcnt <= 4'h1;
                end else if (rcnt == 4'h1) begin
                    rflag <= bit_d;
                    rcnt <= 4'h2;
                    if (!(rprev ^ rpar ^ bit_d)) par_p <= 1'b1;
                end else if (rflag && rcnt == 4'h3) begin
                    rcnt <= 4'h0;
                    rprev <= rsh[7] ^ bit_d;
                    if (resc) begin
                        resc <= 1'b0;
                        if ({rsh[7], bit_d} == `LIE_CODE_FCT) null_p <= 1'b1;
                        else esc_p <= 1'b1;
                    end else if ({rsh[7], bit_d} == `LIE_CODE_FCT) begin
                        fct_p <= 1'b1;
                    end else if ({rsh[7], bit_d} == `LIE_CODE_ESC) begin
                        resc <= 1'b1;
                    end else begin
                        nchar_p <= 1'b1;
                        rchar <= {8'h80, bit_d == 1'b0};
                    end
                end else if (!rflag && rcnt == 4'h9) begin
                    rcnt <= 4'h0;
                    rprev <= ^{bit_d, rsh[7:1]};
                    resc <= 1'b0;
                    if (resc) time_p <= 1'b1;
                    else nchar_p <= 1'b1;
                    rchar <= {1'b0, bit_d, rsh[7:1]};
                end else begin
                    rsh <= {bit_d, rsh[7:1]};
                    rcnt <= rcnt + 4'h1;
                end
            end
        end
    end

    // transmit credit, overflow is a credit error
    always_ff @(posedge sys_clk) begin
        if (reset || !tx_on) tx_cred <= 6'h00;
        else if (fct_p && is_state(state, 6'h30) && tx_cred <= `LIE_CREDIT_MAX - `LIE_FCT_CREDIT)
            tx_cred <= tx_cred + `LIE_FCT_CREDIT - {5'h00, host_sent};
        else if (host_sent) tx_cred <= tx_cred - 6'h01;
    end

    // receive credit granted by our FCTs
    always_ff @(posedge sys_clk) begin
        if (reset || !tx_on) rx_cred <= 6'h00;
        else if (fct_sent) rx_cred <= rx_cred + `LIE_FCT_CREDIT - {5'h00, nchar_p && rx_cred != 0};
        else if (nchar_p && rx_cred != 6'h00) rx_cred <= rx_cred - 6'h01;
    end

    assign cred_p = state == lie_pkg::st_run && ((nchar_p && rx_cred == 6'h00)
        || (fct_p && tx_cred > `LIE_CREDIT_MAX - `LIE_FCT_CREDIT));

    // room pulses owed as FCTs; capped at 7 owed, rx_cred itself not checked against max
    always_ff @(posedge sys_clk) begin
        if (reset || !rx_on) owed <= 3'h0;
        else if (host_room && owed != 3'h7 && !fct_sent) owed <= owed + 3'h1;
        else if (fct_sent && !(host_room && owed != 3'h7)) owed <= owed - 3'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (reset || state != lie_pkg::st_run) begin
            rx_valid <= 1'b0;
            rx_data <= 9'h000;
            last_eop <= 1'b0;
        end else begin
            rx_valid <= nchar_p && !(rchar[8] && last_eop) && rx_cred != 6'h00;
            rx_data <= rchar;
            if (nchar_p) last_eop <= rchar[8];
        end
    end

    // bit-rate enable
    always_ff @(posedge sys_clk) begin
        if (reset || div == `LIE_TX_DIV - 5'h01) div <= 5'h00;
        else div <= div + 5'h01;
    end
    assign tick = div == `LIE_TX_DIV - 5'h01;

    // NULL by default, FCT only from Connecting on
    always_comb begin
        nvec = ctl_char(`LIE_CODE_ESC, tprev);
        nprev = 1'b0;
        npend = 1'b1;
        nhost = 1'b0;
        nfct = 1'b0;
        if (pend) begin
            nvec = ctl_char(`LIE_CODE_FCT, tprev);
            npend = 1'b0;
        end else if (owed != 3'h0 && is_state(state, 6'h30)) begin
            nvec = ctl_char(`LIE_CODE_FCT, tprev);
            npend = 1'b0;
            nfct = 1'b1;
        end else if (state == lie_pkg::st_run && tx_valid && tx_cred != 6'h00 && !tx_ack) begin
            npend = 1'b0;
            nhost = 1'b1;
            if (tx_data[8]) begin
                nvec = ctl_char(tx_data[0] ? `LIE_CODE_EEP : `LIE_CODE_EOP, tprev);
                nprev = 1'b1;
            end else begin
                nvec = {tx_data[7:0], 1'b0, ~tprev};
                nprev = ^tx_data[7:0];
            end
        end
        nlen = nvec[1] ? 4'h4 : 4'ha;
    end

    assign fct_sent = tick && tx_on && tlen == 4'h0 && nfct;
    assign host_sent = tick && tx_on && tlen == 4'h0 && nhost;

    // data-strobe encoder; ordered stop: shifter, strobe, data
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tsh <= 10'h000;
            tlen <= 4'h0;
            tprev <= 1'b0;
            pend <= 1'b0;
            data_out <= 1'b0;
            strobe_out <= 1'b0;
            tx_ack <= 1'b0;
        end else if (!tx_on) begin
            tlen <= 4'h0;
            pend <= 1'b0;
            tprev <= 1'b0;
            tx_ack <= 1'b0;
            if (tick && strobe_out) strobe_out <= 1'b0;
            else if (tick) data_out <= 1'b0;
        end else begin
            tx_ack <= host_sent;
            if (tick) begin
                data_out <= tlen != 4'h0 ? tsh[0] : nvec[0];
                if ((tlen != 4'h0 ? tsh[0] : nvec[0]) == data_out) strobe_out <= ~strobe_out;
                if (tlen != 4'h0) begin
                    tsh <= {1'b0, tsh[9:1]};
                    tlen <= tlen - 4'h1;
                end else begin
                    tsh <= {1'b0, nvec[9:1]};
                    tlen <= nlen - 4'h1;
                    tprev <= nprev;
                    pend <= npend;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_ready <= 1'b0;
            link_running <= 1'b0;
        end else begin
            tx_ready <= state == lie_pkg::st_run && tx_cred != 6'h00;
            link_running <= state == lie_pkg::st_run;
        end
    end

    // apb: one wait state, read data registered with pready
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    `LIE_ADDR_CTRL: if (!pwrite) prdata <= {29'h0, ctrl};
                    `LIE_ADDR_STATUS: begin
                        if (!pwrite) prdata <= {2'h0, rx_cred, 2'h0, tx_cred, 7'h00,
                            got_null, 2'h0, state};
                        else pslverr <= 1'b1;
                    end
                    `LIE_ADDR_ERRS: if (!pwrite) prdata <= {27'h0, errs};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) ctrl <= `LIE_CTRL_RESET;
        else if (apb_done && pwrite && paddr == `LIE_ADDR_CTRL) ctrl <= pwdata[2:0];
    end

    // sticky error bits, write one to clear; a new event beats the clear
    always_ff @(posedge sys_clk) begin
        if (reset) errs <= 5'h00;
        else errs <= (errs & ~((apb_done && pwrite && paddr == `LIE_ADDR_ERRS) ? pwdata[4:0]
            : 5'h00)) | {seq_p, cred_p, esc_p, par_p, disc_p};
    end
endmodule

// ### design/lie_pkg.sv
// Purpose: types of the link exchange block
// Assumes: nothing
// Notes: one-hot state codes
package lie_pkg;
    typedef enum logic [5:0] {
        st_err_reset = 6'h01,
        st_err_wait = 6'h02,
        st_ready = 6'h04,
        st_started = 6'h08,
        st_connecting = 6'h10,
        st_run = 6'h20
    } lie_state_t;
endpackage

// ### design/lie_rx_front.sv
// Purpose: sample data/strobe pins, recover bits, detect silence
// Assumes: pin edges at least two sys_clk cycles apart
// Notes: both pins changing in one sample is not resolved
`include "lie_defines.svh"
module lie_rx_front (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic data_in,
    input wire logic strobe_in,
    input wire logic rx_enable,
    output logic bit_valid,
    output logic bit_data,
    output logic disc_err
);
    localparam logic [7:0] DISC_CYC = 8'(`LIE_CYC_DISC);
    logic d1, d2, d3, s1, s2, s3;
    logic armed;
    logic [7:0] idle_cnt;
    logic edge_seen;

    assign edge_seen = (d2 ^ d3) | (s2 ^ s3);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            d1 <= 1'b0;
            d2 <= 1'b0;
            d3 <= 1'b0;
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            d1 <= data_in;
            d2 <= d1;
            d3 <= d2;
            s1 <= strobe_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bit_valid <= 1'b0;
            bit_data <= 1'b0;
        end else begin
            bit_valid <= rx_enable & edge_seen;
            bit_data <= d2;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !rx_enable) begin
            armed <= 1'b0;
            idle_cnt <= 8'h00;
            disc_err <= 1'b0;
        end else begin
            disc_err <= 1'b0;
            if (edge_seen) begin
                armed <= 1'b1;
                idle_cnt <= 8'h00;
            end else if (armed) begin
                if (idle_cnt == DISC_CYC - 8'h01) begin
                    disc_err <= 1'b1;
                    armed <= 1'b0;
                end
                idle_cnt <= idle_cnt + 8'h01;
            end
        end
    end
endmodule

// ### tb/lie_chk.sv
// Purpose: port checks of the link exchange block
// Assumes: one clock domain, synchronous reset
// Notes: state is hidden, so checks lean on port effects
module lie_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_valid,
    input wire logic tx_ack,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic link_running,
    input wire logic data_in,
    input wire logic strobe_in,
    input wire logic data_out,
    input wire logic strobe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    int quiet;
    int idle;
    // saturating, so long runs never wrap
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            quiet <= 0;
        end else if (quiet < 5000) begin
            quiet <= quiet + 1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if ($changed(data_in) || $changed(strobe_in)) begin
            idle <= 0;
        end else if (idle < 1000) begin
            idle <= idle + 1;
        end
    end
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_reset_idle: assert property ($fell(reset) |-> !link_running && !tx_ready
        && !data_out && !strobe_out) else $error("outputs busy after reset");
    a_tx_quiet: assert property (quiet < 4790 |-> !data_out && !strobe_out)
        else $error("link driven before ready");
    a_one_edge: assert property (!($changed(data_out) && $changed(strobe_out)))
        else $error("data and strobe moved together");
    a_apb_answer: assert property (s_access |=> s_answer)
        else $error("bus answer late or long");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_ack_pulse: assert property (tx_ack |-> $past(tx_valid) ##1 !tx_ack)
        else $error("ack without offer or too long");
    a_ready_run: assert property (tx_ready |->
        (link_running || $past(link_running)) or (##1 link_running))
        else $error("tx ready outside run");
    a_disc_reset: assert property (idle > 280 |-> !link_running)
        else $error("silent line left link running");
    a_rx_run: assert property (rx_valid |->
        (link_running || $past(link_running)) ##1 !rx_valid)
        else $error("char delivered outside run");
endmodule

bind lie_link_exchange lie_chk u_chk (.sys_clk, .reset, .psel, .penable, .pready,
    .pslverr, .tx_valid, .tx_ack, .tx_ready, .rx_valid, .link_running, .data_in,
    .strobe_in, .data_out, .strobe_out);

// ### tb/lie_peer.sv
// Purpose: far-end link peer sending data-strobe characters
// Assumes: one bit per link_clk rising edge
// Notes: lines hold level when idle, like a stopped sender
module lie_peer (
    input wire logic link_clk,
    input wire logic data_in,
    input wire logic strobe_in,
    output logic data_out,
    output logic strobe_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic run = 0;
    logic par = 0;
    int heard = 0;
    logic [9:0] q[$];
    int rpos = -1;
    logic rflag = 0;
    logic [8:0] hsh = '0;
    logic [7:0] rb = '0;
    logic [7:0] seen[$];
    initial begin
        data_out = 0;
        strobe_out = 0;
    end
    // one pin edge per bit: hunt a NULL, then frame and keep data bytes
    always @(data_in or strobe_in) begin
        heard++;
        if (rpos < 0) begin
            hsh = {hsh[7:0], data_in};
            if (hsh == 9'h0e8) rpos = 1;
        end else if (rpos == 1) begin
            rflag = data_in;
            rpos = 2;
        end else begin
            rb = {data_in, rb[7:1]};
            rpos = (rpos == (rflag ? 3 : 9)) ? 0 : rpos + 1;
            if (rpos == 0 && !rflag) seen.push_back(rb);
        end
    end
    task automatic put(input logic b);
        @(posedge link_clk);
        if (b == data_out) begin
            strobe_out <= ~strobe_out;
        end else begin
            data_out <= b;
        end
    endtask
    // bit 9 marks data; else [1:0] is the control code
    task automatic send(input logic [9:0] ch);
        int n;
        n = ch[9] ? 8 : 2;
        put(par ^ ch[9]);
        put(~ch[9]);
        for (int i = 0; i < n; i++) put(ch[9] ? ch[i] : ch[1 - i]);
        par = ch[9] ? ^ch[7:0] : ^ch[1:0];
    endtask
    always begin
        if (q.size() > 0 && (q[0] != 10'h000 || heard > 16)) begin
            send(q.pop_front());
        end else if (run) begin
            send(10'h003);
            send(10'h000);
        end else begin
            @(posedge link_clk);
        end
    end
endmodule

// ### tb/link_init_exchange_fsm_test.sv
// Purpose: register, handshake and link bring-up tests
// Assumes: peer model drives the link pins
// Notes: state and credits read back through status
module link_init_exchange_fsm_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 0, link_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic host_room = 0, tx_valid = 0, err, pready, pslverr, tx_ack, tx_ready;
    logic rx_valid, link_running, d_up, s_up, d_dn, s_dn;
    logic [7:0] paddr = '0;
    logic [8:0] tx_data = '0, rx_data;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [8:0] got[$];
    int bad_count = 0, checks = 0, cyc = 0, waited, mark;
    always #2 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    always @(posedge sys_clk) cyc <= reset ? 0 : cyc + 1;
    always @(posedge sys_clk) if (rx_valid === 1'b1) got.push_back(rx_data);
    lie_link_exchange dut (
        .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .host_room, .tx_valid, .tx_data, .tx_ack, .tx_ready, .rx_valid, .rx_data,
        .link_running, .data_in(d_up), .strobe_in(s_up), .data_out(d_dn), .strobe_out(s_dn)
    );
    lie_peer peer (
        .link_clk, .data_in(d_dn), .strobe_in(s_dn), .data_out(d_up), .strobe_out(s_up)
    );
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        if (bad_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        waited = 0;
        while (s !== v) begin
            @(posedge sys_clk);
            waited++;
            if (waited > lim) begin
                bad_count++;
                $display("ERROR %0t: wait timed out", $time);
                summarize();
            end
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1;
        wait_sig(pready, 1, 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge sys_clk);
    endtask
    task automatic status(input logic [31:0] exp);
        apb(0, 8'h04, 32'h0);
        check(rd, exp);
    endtask
    task automatic at(input int n);
        while (cyc < n) @(posedge sys_clk);
    endtask
    task automatic room;
        host_room <= 1;
        @(posedge sys_clk);
        host_room <= 0;
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 0;
        status(32'h1);
        apb(1, 8'h04, 32'h1);
        check({31'h0, err}, 32'h1);
        apb(0, 8'h0c, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000);
        apb(1, 8'h00, 32'h3);
        apb(0, 8'h00, 32'h0);
        check(rd, 32'h3);
        apb(1, 8'h00, 32'h0);
        at(1590);
        status(32'h1);
        at(1610);
        status(32'h2);
        peer.run = 1;
        at(4790);
        status(32'h102);
        at(4810);
        status(32'h104);
        room();
        room();
        peer.q.push_back(10'h000);
        // autostart only: the peer's nulls must enable the link
        apb(1, 8'h00, 32'h4);
        wait_sig(link_running, 1, 3000);
        status(32'h1008_0120);
        for (int i = 0; i < 8; i++) begin
            check({31'h0, tx_ready}, 32'h1);
            tx_data <= 9'h0a0 + 9'(i);
            tx_valid <= 1;
            wait_sig(tx_ack, 1, 600);
            tx_valid <= 0;
            @(posedge sys_clk);
        end
        repeat (3) @(posedge sys_clk);
        check({31'h0, tx_ready}, 32'h0);
        peer.q = '{10'h25a, 10'h001, 10'h001, 10'h2c3};
        repeat (800) @(posedge sys_clk);
        check(32'(got.size()), 32'h3);
        check(32'(got[0]), 32'h5a);
        check(32'(got[1]), 32'h100);
        check(32'(got[2]), 32'hc3);
        check(32'(peer.seen.size()), 32'h8);
        for (int i = 0; i < 8; i++) begin
            check(32'(peer.seen[i]), 32'h0a0 + 32'(i));
        end
        peer.run = 0;
        wait_sig(link_running, 0, 500);
        mark = cyc;
        check(32'(waited >= 213), 32'h1);
        status(32'h1);
        apb(0, 8'h08, 32'h0);
        check(rd, 32'h1);
        apb(1, 8'h08, 32'h1f);
        apb(0, 8'h08, 32'h0);
        check(rd, 32'h0);
        apb(1, 8'h00, 32'h2);
        // ordered stop needs two bit ticks after leaving run
        repeat (60) @(posedge sys_clk);
        check({30'h0, d_dn, s_dn}, 32'h0);
        at(mark + 4900);
        status(32'h8);
        at(mark + 7900);
        status(32'h8);
        at(mark + 8100);
        status(32'h1);
        summarize();
    end
endmodule
